//--- rtl/event_pulse_notifier_regs.vh
// Constants for the event pulse notifier: mode codes, class select, timing.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef EVENT_PULSE_NOTIFIER_REGS_VH
`define EVENT_PULSE_NOTIFIER_REGS_VH

`define MODE_INIT      3'h0
`define MODE_NORMAL    3'h1
`define MODE_STOP      3'h2
`define MODE_SLEEP     3'h3
`define MODE_RESTART   3'h4
`define MODE_FAILSAFE  3'h5

`define CLASS_WAKE_ONLY 1'h0
`define CLASS_GLOBAL    1'h1

`define CLK_MHZ          50
`define PULSE_WIDTH_US   100
`define MIN_GAP_US       100
`define CFG_FILTER_US    7
`define PULSE_WIDTH_CYC  (`PULSE_WIDTH_US * `CLK_MHZ)
`define MIN_GAP_CYC      (`MIN_GAP_US * `CLK_MHZ)
`define CFG_FILTER_CYC   (`CFG_FILTER_US * `CLK_MHZ)

`endif

//--- rtl/event_latch_bank.v
// Sticky latch bank: one latched flag per source bit, visible copy refreshed on load.
// Assumes sources and clears are in the clk domain.
`timescale 1ns/10ps
`default_nettype none

module event_latch_bank #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire             clk,
	input  wire             sys_rst,
	// Events and control
	input  wire [WIDTH-1:0] set_bits,
	input  wire [WIDTH-1:0] clear_bits,
	input  wire             load,
	// State
	output reg  [WIDTH-1:0] pending_q,
	output reg  [WIDTH-1:0] shown_q
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (sys_rst) begin
					pending_q[i] <= 1'h0;
					shown_q[i]   <= 1'h0;
				end else begin
					// Set wins over clear so no event is lost
					if (set_bits[i])
						pending_q[i] <= 1'h1;
					else if (clear_bits[i])
						pending_q[i] <= 1'h0;
					if (clear_bits[i] && !set_bits[i])
						shown_q[i] <= 1'h0;
					else if (load)
						shown_q[i] <= pending_q[i] | set_bits[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

//--- rtl/event_pulse_notifier.v
// Event notifier: turns latched wake and failure events into active-low pulses.
// Assumes all flag inputs are clk-domain strobes; the event pin read-back is async.
`timescale 1ns/10ps
`default_nettype none
`include "event_pulse_notifier_regs.vh"

module event_pulse_notifier #(
	parameter WA_W = 8,
	parameter WB_W = 8,
	parameter FL_W = 16,
	parameter PULSE_CYC = `PULSE_WIDTH_CYC,
	parameter GAP_CYC   = `MIN_GAP_CYC
) (
	// Clock and reset
	input  wire            clk,
	input  wire            sys_rst,
	// Device mode
	input  wire [2:0]      mode,
	input  wire            stop_entry,
	input  wire            class_global,
	// Wake sources, status a
	input  wire [WA_W-1:0] wake_event_a,
	input  wire [WA_W-1:0] wake_enable_a,
	input  wire [WA_W-1:0] wake_clear_a,
	// Wake sources, status b (fail-output pins as wake inputs among them)
	input  wire [WB_W-1:0] wake_event_b,
	input  wire [WB_W-1:0] wake_enable_b,
	input  wire [WB_W-1:0] wake_clear_b,
	// Failure flags of other status registers
	input  wire [FL_W-1:0] fail_event,
	input  wire [FL_W-1:0] fail_clear,
	input  wire [FL_W-1:0] fail_no_pulse,
	// Event pin
	input  wire            event_pin_in,
	output reg             event_out_n,
	output reg             event_oe,
	// Status and configuration
	output reg  [WA_W-1:0] wake_status_a,
	output reg  [WB_W-1:0] wake_status_b,
	output reg  [FL_W-1:0] fail_status,
	output reg             hw_config_q,
	output reg             pulse_busy
);

	////////////////////////////////////////////////////////////////
	localparam ST_IDLE  = 2'h0;
	localparam ST_PULSE = 2'h1;
	localparam ST_GAP   = 2'h2;

	localparam CNT_W = 16;
	// Counts beyond 16 bits would wrap; the documented defaults need 13
	localparam integer PULSE_LAST_I = PULSE_CYC - 1;
	localparam integer GAP_LAST_I   = GAP_CYC - 1;
	localparam integer CFG_LAST_I   = `CFG_FILTER_CYC - 1;
	localparam [CNT_W-1:0] PULSE_LAST = PULSE_LAST_I[CNT_W-1:0];
	localparam [CNT_W-1:0] GAP_LAST   = GAP_LAST_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CFG_LAST   = CFG_LAST_I[CNT_W-1:0];

	reg  [1:0]       state_q;
	reg  [CNT_W-1:0] cnt_q;
	reg              req_q;
	reg              stop_req_q;
	reg              fall_q;
	wire [WA_W-1:0]  pend_a;
	wire [WB_W-1:0]  pend_b;
	wire [FL_W-1:0]  pend_f;
	wire [WA_W-1:0]  shown_a;
	wire [WB_W-1:0]  shown_b;
	wire [FL_W-1:0]  shown_f;

	////////////////////////////////////////////////////////////////
	// Only enabled wake sources latch; masked sources vanish
	wire [WA_W-1:0] set_a = wake_event_a & wake_enable_a;
	wire [WB_W-1:0] set_b = wake_event_b & wake_enable_b;

	event_latch_bank #(.WIDTH(WA_W)) u_bank_a (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.set_bits   (set_a),
		.clear_bits (wake_clear_a),
		.load       (fall_q),
		.pending_q  (pend_a),
		.shown_q    (shown_a)
	);

	event_latch_bank #(.WIDTH(WB_W)) u_bank_b (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.set_bits   (set_b),
		.clear_bits (wake_clear_b),
		.load       (fall_q),
		.pending_q  (pend_b),
		.shown_q    (shown_b)
	);

	event_latch_bank #(.WIDTH(FL_W)) u_bank_f (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.set_bits   (fail_event),
		.clear_bits (fail_clear),
		.load       (fall_q),
		.pending_q  (pend_f),
		.shown_q    (shown_f)
	);

	////////////////////////////////////////////////////////////////
	// Restart and fail-safe flags latch but are kept off the trigger
	wire fail_trig = (class_global == `CLASS_GLOBAL) &&
		(|(fail_event & ~fail_no_pulse));
	wire wake_trig = (|set_a) | (|set_b);
	wire pulse_mode = (mode == `MODE_NORMAL) || (mode == `MODE_STOP);
	wire wake_left = (|pend_a) | (|pend_b);

	reg req_d;
	reg stop_req_d;

	// Requests are held so a pulse delayed by the gap still fires
	// A request raised in sleep or init waits here; its events stay latched
	always @* begin
		req_d      = req_q;
		stop_req_d = stop_req_q;
		if (wake_trig || fail_trig)
			req_d = 1'h1;
		else if (state_q == ST_IDLE && pulse_mode)
			req_d = 1'h0;
		if (stop_entry && wake_left)
			stop_req_d = 1'h1;
		else if (state_q == ST_IDLE && pulse_mode)
			stop_req_d = 1'h0;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			req_q      <= 1'h0;
			stop_req_q <= 1'h0;
		end else begin
			req_q      <= req_d;
			stop_req_q <= stop_req_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pulse engine; it never writes the mode, which is an input only
	reg  [1:0]       state_d;
	reg  [CNT_W-1:0] cnt_d;
	reg              out_n_d;
	reg              fall_d;
	reg              busy_d;

	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		out_n_d = event_out_n;
		fall_d  = 1'h0;
		busy_d  = pulse_busy;
		case (state_q)
			ST_IDLE: begin
				busy_d = 1'h0;
				if (pulse_mode && (req_q || stop_req_q)) begin
					state_d = ST_PULSE;
					cnt_d   = {CNT_W{1'b0}};
					out_n_d = 1'h0;
					fall_d  = 1'h1;
					busy_d  = 1'h1;
				end
			end
			ST_PULSE: begin
				// The edge that pulls the pin low counts as the first low cycle
				if (cnt_q == PULSE_LAST) begin
					state_d = ST_GAP;
					cnt_d   = {CNT_W{1'b0}};
					out_n_d = 1'h1;
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end
			ST_GAP: begin
				// One short: the idle edge that starts the next pulse ends the gap
				if (cnt_q == GAP_LAST - 16'h0001) begin
					state_d = ST_IDLE;
					cnt_d   = {CNT_W{1'b0}};
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end
			default: begin
				state_d = ST_IDLE;
				out_n_d = 1'h1;
			end
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			state_q     <= ST_IDLE;
			cnt_q       <= {CNT_W{1'b0}};
			event_out_n <= 1'h1;
			fall_q      <= 1'h0;
			pulse_busy  <= 1'h0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			event_out_n <= out_n_d;
			fall_q      <= fall_d;
			pulse_busy  <= busy_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Visible status lags the bank copy by one register stage

	always @(posedge clk) begin
		if (sys_rst) begin
			wake_status_a <= {WA_W{1'b0}};
			wake_status_b <= {WB_W{1'b0}};
			fail_status   <= {FL_W{1'b0}};
		end else begin
			wake_status_a <= shown_a;
			wake_status_b <= shown_b;
			fail_status   <= shown_f;
		end
	end

	////////////////////////////////////////////////////////////////
	// Configuration sampling in init mode: pin released, three-stage sync
	reg              pin_s1_q;
	reg              pin_s2_q;
	reg              pin_s3_q;
	reg              cfg_cand_q;
	reg  [CNT_W-1:0] cfg_cnt_q;

	reg              cfg_cand_d;
	reg  [CNT_W-1:0] cfg_cnt_d;
	reg              hw_config_d;

	// Only the second and third stages are compared; the first may be metastable
	always @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_q <= 1'h0;
			pin_s2_q <= 1'h0;
			pin_s3_q <= 1'h0;
		end else begin
			pin_s1_q <= event_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// The strap must hold for the whole filter time before it is taken
	always @* begin
		cfg_cand_d  = cfg_cand_q;
		cfg_cnt_d   = {CNT_W{1'b0}};
		hw_config_d = hw_config_q;
		if (mode == `MODE_INIT && pin_s2_q == pin_s3_q) begin
			if (pin_s3_q != cfg_cand_q) begin
				cfg_cand_d = pin_s3_q;
			end else if (cfg_cnt_q == CFG_LAST) begin
				cfg_cnt_d   = cfg_cnt_q;
				hw_config_d = cfg_cand_q;
			end else begin
				cfg_cnt_d = cfg_cnt_q + 16'h0001;
			end
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			cfg_cand_q  <= 1'h0;
			cfg_cnt_q   <= {CNT_W{1'b0}};
			hw_config_q <= 1'h0;
			event_oe    <= 1'h0;
		end else begin
			cfg_cand_q  <= cfg_cand_d;
			cfg_cnt_q   <= cfg_cnt_d;
			hw_config_q <= hw_config_d;
			// Driving during init would mask the strap being read
			event_oe    <= (mode != `MODE_INIT);
		end
	end

endmodule

`default_nettype wire

//--- tb/event_pulse_notifier_properties.sv
// Concurrent checks on the event pulse notifier, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "event_pulse_notifier_regs.vh"

module event_pulse_notifier_properties #(
	parameter WA_W      = 8,
	parameter WB_W      = 8,
	parameter FL_W      = 16,
	parameter PULSE_CYC = 20,
	parameter GAP_CYC   = 20
) (
	// Clock, reset, control
	input wire logic            clk,
	input wire logic            sys_rst,
	input wire logic [2:0]      mode,
	input wire logic            stop_entry,
	// Wake and status
	input wire logic [WA_W-1:0] wake_event_a,
	input wire logic [WA_W-1:0] wake_enable_a,
	input wire logic [WA_W-1:0] wake_clear_a,
	input wire logic [WA_W-1:0] wake_status_a,
	input wire logic [WB_W-1:0] wake_status_b,
	input wire logic [FL_W-1:0] fail_status,
	// Pin
	input wire logic            event_out_n,
	input wire logic            event_oe
);
	logic [15:0] lo_q;
	logic [15:0] hi_q;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// High run saturates so long idle time cannot wrap
	always @(posedge clk) begin
		if (sys_rst) begin
			lo_q <= 16'h0;
			hi_q <= 16'(GAP_CYC);
		end else begin
			lo_q <= event_out_n ? 16'h0 : lo_q + 16'h1;
			hi_q <= !event_out_n ? 16'h0 : (hi_q < GAP_CYC ? hi_q + 16'h1 : hi_q);
		end
	end
	////////////////////////////////////////////////////////////////////////
	pulse_width_a: assert property ($rose(event_out_n) |-> lo_q == PULSE_CYC)
		else $error("pulse width wrong");
	min_gap_a: assert property ($fell(event_out_n) |-> hi_q >= GAP_CYC)
		else $error("gap too short");
	pulse_mode_a: assert property ($fell(event_out_n) |->
		$past(mode) inside {`MODE_NORMAL, `MODE_STOP})
		else $error("pulse outside normal or stop");
	status_fall_a: assert property ($fell(event_out_n) |->
		##2 (|wake_status_a || |wake_status_b || |fail_status))
		else $error("status not refreshed");
	status_sticky_a: assert property ((wake_clear_a == 0) [*4] |->
		($past(wake_status_a, 2) & ~wake_status_a) == 0)
		else $error("status bit lost");
	wake_trigger_a: assert property ((mode == `MODE_NORMAL && event_out_n
		&& hi_q >= GAP_CYC && |(wake_event_a & wake_enable_a)) |-> ##[1:2] !event_out_n)
		else $error("wake event not signalled");
	stop_pulse_a: assert property ((stop_entry && mode == `MODE_STOP && event_out_n
		&& hi_q >= GAP_CYC && |wake_status_b) |-> ##[1:2] !event_out_n)
		else $error("stop entry not signalled");
	init_oe_a: assert property ((mode == `MODE_INIT) [*2] |-> !event_oe)
		else $error("pin driven in init");
	cover property ($fell(event_out_n));
	cover property ($fell(event_out_n) && mode == `MODE_STOP);
	cover property ($rose(event_out_n));
endmodule

bind event_pulse_notifier event_pulse_notifier_properties #(.WA_W(WA_W), .WB_W(WB_W),
	.FL_W(FL_W), .PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) i_props (.clk, .sys_rst, .mode,
	.stop_entry, .wake_event_a, .wake_enable_a, .wake_clear_a, .wake_status_a, .wake_status_b,
	.fail_status, .event_out_n, .event_oe);
`default_nettype wire

//--- tb/event_mcu_model.sv
// Microcontroller side: counts pulses, measures last width and gap.
// Assumes a strap level holds the pin while the device does not drive it.
`timescale 1ns/10ps
`default_nettype none

module event_mcu_model (
	input  wire logic clk,
	input  wire logic event_out_n,
	input  wire logic event_oe,
	input  wire logic cfg_level,
	output wire logic pin,
	output var  int   pulses,
	output var  int   width,
	output var  int   gap
);
	int   run = 0;
	logic last = 1'b1;
	assign pin = event_oe ? event_out_n : cfg_level;
	initial begin
		pulses = 0;
		width = 0;
		gap = 0;
	end
	always @(posedge clk) begin
		if (event_out_n !== last) begin
			if (last) begin
				gap = run;
				pulses = pulses + 1;
			end else
				width = run;
			run = 0;
		end
		run = run + 1;
		last = event_out_n;
	end
endmodule
`default_nettype wire

//--- tb/event_pulse_notifier_test.sv
// Testbench for the event pulse notifier with a microcontroller model.
// Assumes short pulse and gap counts of 20 cycles.
`timescale 1ns/10ps
`default_nettype none
`include "event_pulse_notifier_regs.vh"

module event_pulse_notifier_test;
	logic        clk = 0, sys_rst = 1, stop_entry = 0, class_global = 0, cfg = 0;
	logic [2:0]  mode = 0;
	logic [7:0]  wake_event_a = 0, wake_enable_a = 8'h01, wake_clear_a = 0;
	logic [7:0]  wake_event_b = 0, wake_enable_b = 8'h02, wake_clear_b = 0;
	logic [15:0] fail_event = 0, fail_clear = 0, fail_no_pulse = 16'h0001;
	wire logic   event_pin_in, event_out_n, event_oe, hw_config_q, pulse_busy;
	wire logic [7:0]  wake_status_a, wake_status_b;
	wire logic [15:0] fail_status;
	int pulses, width, gap, failures = 0, tests_run = 0, i;
	always #10 clk = ~clk;
	event_pulse_notifier #(.PULSE_CYC(20), .GAP_CYC(20)) i_event_pulse_notifier (.clk,
		.sys_rst, .mode, .stop_entry, .class_global, .wake_event_a, .wake_enable_a,
		.wake_clear_a, .wake_event_b, .wake_enable_b, .wake_clear_b, .fail_event, .fail_clear,
		.fail_no_pulse, .event_pin_in, .event_out_n, .event_oe, .wake_status_a,
		.wake_status_b, .fail_status, .hw_config_q, .pulse_busy);
	event_mcu_model i_event_mcu_model (.clk, .event_out_n, .event_oe, .cfg_level(cfg),
		.pin(event_pin_in), .pulses, .width, .gap);
	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle strobes, then a window long enough for two pulses
	task fire(input [7:0] a, input [7:0] b, input [15:0] f, input s, input [31:0] want);
		int n0;
		n0 = pulses;
		{wake_event_a, wake_event_b, fail_event, stop_entry} = {a, b, f, s};
		@(negedge clk);
		{wake_event_a, wake_event_b, fail_event, stop_entry} = 0;
		repeat (100) @(negedge clk);
		check(pulses - n0, want);
	endtask
	task clr;
		{wake_clear_a, wake_clear_b, fail_clear} = '1;
		@(negedge clk);
		{wake_clear_a, wake_clear_b, fail_clear} = 0;
		repeat (3) @(negedge clk);
	endtask
	task results;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		sys_rst = 0;
		check({event_out_n, event_oe, pulse_busy, wake_status_a}, 11'h400);
		cfg = 1;
		repeat (100) @(negedge clk);
		check(hw_config_q, 0);
		for (i = 0; i < 1000 && hw_config_q !== 1'b1; i++) @(negedge clk);
		check(hw_config_q, 1);
		mode = `MODE_NORMAL;
		fire(8'h01, 0, 0, 0, 1);
		check(width, 20);
		check(wake_status_a, 8'h01);
		fire(8'h02, 0, 0, 0, 0);
		fire(0, 0, 16'h0010, 0, 0);
		wake_event_b = 8'h02;
		@(negedge clk);
		fire(8'h01, 0, 0, 0, 2);
		check(gap >= 20, 1);
		clr;
		check(wake_status_a, 0);
		@(negedge clk);
		check(wake_status_a, 0);
		class_global = 1;
		fire(0, 0, 16'h0001, 0, 0);
		fire(0, 0, 16'h0010, 0, 1);
		check(fail_status[4], 1);
		clr;
		mode = `MODE_SLEEP;
		fire(0, 8'h02, 0, 0, 0);
		mode = `MODE_NORMAL;
		fire(0, 0, 0, 0, 1);
		check(wake_status_b, 8'h02);
		mode = `MODE_STOP;
		fire(0, 0, 0, 1, 1);
		wake_event_a = 8'h01;
		@(negedge clk);
		wake_event_a = 0;
		@(negedge clk);
		check({event_out_n, pulse_busy}, 2'h1);
		repeat (20) @(negedge clk);
		check({event_out_n, pulse_busy}, 2'h3);
		repeat (20) @(negedge clk);
		check({event_out_n, pulse_busy}, 2'h2);
		clr;
		fire(0, 0, 0, 1, 0);
		results;
	end
endmodule
`default_nettype wire
